/* File: hw/serial_microport_bootload.sv */
// serial microcontroller port with register access and program ram bootload.
// assumes the pins are asynchronous and oversampled by ref_clk_i; the device
// register file and the program ram sit outside on the same clock.
//
// Operation
// - sclk high at select: lsb-first, shared line
// - sclk low at select: msb-first, split lines
// - half duplex, each side ignores idle line
// - eight edges command, eight edges data
// - release shared line while select is high
// - data lsb-first or msb-first per mode
// - command byte arranged differently per mode
// - sample on rising, change on falling
// - registers read/write, program ram write only
// - boot bit in control register at 3fh
// - boot mode writes elsewhere fill program ram
// - fill writes use generated address only
// - reads leave fill address untouched
// - only first 4096 fill writes stored
// - signature updated by fill data only
// - clearing boot bit resets address, signature
// - hardware reset restores ready bootload state
// - control write stores nothing in ram
// - bootload identical in both serial modes
// - boot reads give control or signature
// - normal accesses reach addressed device register
// - ram execution with boot bit clear resets address, signature
module serial_microport_bootload #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic serial_io_a_i,
  output logic serial_io_a_o,
  output logic serial_io_a_oe_o,
  input wire logic serial_rx_b_i,
  // device register port
  output logic [5:0] dev_addr_o,
  output logic [7:0] dev_wdata_o,
  output logic dev_wr_o,
  input wire logic [7:0] dev_rdata_i,
  // program ram write port
  output logic ram_valid_o,
  output microport_pkg::fill_word_s ram_word_o,
  input wire logic ram_ready_i,
  // execution control
  output logic boot_mode_o,
  output logic exec_ram_o
);

  // ==========================================================================
  // elaboration check
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("serial_microport_bootload needs a fifo depth of at least two");
  end

  // ==========================================================================
  // declarations
  microport_pkg::port_state_s st; // registered state
  microport_pkg::port_state_s nx; // next state
  logic fifo_in_ready; // stalls the pending ram write
  logic sclk_rise; // rising serial clock edge
  logic sclk_fall; // falling serial clock edge
  logic cs_fall; // start of a session
  logic rx_bit; // received line for this mode
  logic [7:0] rx_byte; // shifter including the new bit
  logic [7:0] rd_val; // value returned by a read
  logic ctrl_wr_ev; // control register written this cycle
  logic [3:0] ctrl_wr_val; // value written to it
  logic fill_ev; // fill byte accepted this cycle
  logic [7:0] sig_new; // signature after the accepted byte

  // ==========================================================================
  // edge finding on the second synchroniser stage only
  // the third stage is history only, so each pin edge is acted on exactly once
  assign sclk_rise = st.sclk_s2 && !st.sclk_s3;
  assign sclk_fall = !st.sclk_s2 && st.sclk_s3;
  assign cs_fall = !st.cs_s2 && st.cs_s3;

  // ==========================================================================
  // next state
  always_comb begin
    nx = st;
    rx_bit = 1'b0;
    rx_byte = st.shreg;
    rd_val = dev_rdata_i;
    ctrl_wr_ev = 1'b0;
    ctrl_wr_val = st.ctrl;
    fill_ev = 1'b0;
    sig_new = st.sig;

    // two flip-flops on every pin before any logic looks at it
    nx.cs_s1 = cs_n_i;
    nx.cs_s2 = st.cs_s1;
    nx.cs_s3 = st.cs_s2;
    nx.sclk_s1 = sclk_i;
    nx.sclk_s2 = st.sclk_s1;
    nx.sclk_s3 = st.sclk_s2;
    nx.ioa_s1 = serial_io_a_i;
    nx.ioa_s2 = st.ioa_s1;
    nx.rxb_s1 = serial_rx_b_i;
    nx.rxb_s2 = st.rxb_s1;

    // device register write strobe lasts one cycle
    nx.dev_wr = 1'b0;

    // pending ram write leaves once the buffer takes it
    if (st.push_valid && fifo_in_ready) begin
      nx.push_valid = 1'b0;
    end

    // shared line carries input in lsb-first mode, else the receive line
    rx_bit = st.lsb_mode ? st.ioa_s2 : st.rxb_s2;
    // lsb-first fills from the top, msb-first from the bottom
    rx_byte = st.lsb_mode ? {rx_bit, st.shreg[7:1]} : {st.shreg[6:0], rx_bit};

    // read value selection
    if (st.addr == microport_pkg::ADDR_CTRL) begin
      rd_val = {microport_pkg::CTRL_PAD, st.ctrl};
    end else if (st.ctrl[microport_pkg::CTRL_BOOT_BIT]) begin
      // program ram is never returned, only control or signature
      rd_val = st.addr[microport_pkg::ADDR_TOP_BIT] ?
               {microport_pkg::CTRL_PAD, st.ctrl} : st.sig;
    end else begin
      rd_val = dev_rdata_i;
    end

    if (st.cs_s2) begin
      // select high: idle and release the shared line
      nx.phase = microport_pkg::ST_IDLE;
      nx.oe = 1'b0;
    end else if (cs_fall) begin
      // clock level at select picks the framing for the whole session
      nx.lsb_mode = st.sclk_s2;
      nx.phase = microport_pkg::ST_CMD;
      nx.bit_cnt = '0;
      nx.oe = 1'b0;
    end else begin
      unique case (st.phase)
        microport_pkg::ST_IDLE: begin
          // a session only starts on a select falling edge
          nx.phase = microport_pkg::ST_IDLE;
        end
        microport_pkg::ST_CMD: begin
          // sample on rising edges only
          if (sclk_rise) begin
            nx.shreg = rx_byte;
            nx.bit_cnt = st.bit_cnt + 1'b1;
            if (st.bit_cnt == microport_pkg::CMD_LAST_EDGE) begin
              // read flag is the first bit on the line in either mode
              if (st.lsb_mode) begin
                nx.rw = rx_byte[microport_pkg::LSB_RW_BIT];
                nx.addr = rx_byte[7:microport_pkg::LSB_ADDR_POS];
              end else begin
                nx.rw = rx_byte[microport_pkg::MSB_RW_BIT];
                nx.addr = rx_byte[5:0];
              end
              nx.phase = microport_pkg::ST_FETCH;
            end
          end
        end
        microport_pkg::ST_FETCH: begin
          // address has been out for a cycle, so external data are settled
          nx.tx = rd_val;
          nx.out_bit = st.lsb_mode ? rd_val[0] : rd_val[microport_pkg::MSB_TOP_BIT];
          // drive only for reads; during writes the host ignores the line
          nx.oe = st.rw;
          nx.phase = microport_pkg::ST_DATA;
        end
        microport_pkg::ST_DATA: begin
          // first bit is already out; shift only after a data rising edge
          if (sclk_fall && st.rw && st.bit_cnt != microport_pkg::DATA_FIRST_EDGE) begin
            nx.tx = st.lsb_mode ? {1'b0, st.tx[7:1]} : {st.tx[6:0], 1'b0};
            nx.out_bit = st.lsb_mode ? st.tx[1] : st.tx[6];
          end
          if (sclk_rise) begin
            nx.bit_cnt = st.bit_cnt + 1'b1;
            // receive line is ignored during reads
            if (!st.rw) begin
              nx.shreg = rx_byte;
            end
            if (st.bit_cnt == microport_pkg::DATA_LAST_EDGE) begin
              nx.phase = microport_pkg::ST_DONE;
              if (!st.rw) begin
                // same decode for both modes once the byte is assembled
                if (st.addr == microport_pkg::ADDR_CTRL) begin
                  ctrl_wr_ev = 1'b1;
                  ctrl_wr_val = rx_byte[3:0];
                end else if (st.ctrl[microport_pkg::CTRL_BOOT_BIT]) begin
                  // a word still waiting for the buffer makes this one drop
                  // limitation: a ram side stalled past the buffer depth loses bytes
                  if (st.fill_cnt < microport_pkg::FILL_LIMIT && !nx.push_valid) begin
                    fill_ev = 1'b1;
                    nx.push_valid = 1'b1;
                    nx.push_word.addr = st.fill_cnt[11:0];
                    nx.push_word.data = rx_byte;
                  end
                end else begin
                  nx.dev_wr = 1'b1;
                  nx.dev_wdata = rx_byte;
                end
              end
            end
          end
        end
        microport_pkg::ST_DONE: begin
          // extra clocks are ignored until select rises
          nx.phase = microport_pkg::ST_DONE;
        end
      endcase
    end

    // signature: shift with fixed feedback, then fold in the byte
    sig_new = {st.sig[6:0], 1'b0} ^
              (st.sig[7] ? microport_pkg::SIG_POLY : 8'h00) ^ nx.push_word.data;
    if (fill_ev) begin
      nx.sig = sig_new;
      nx.fill_cnt = st.fill_cnt + 1'b1;
    end

    // control write; boot bit clear restarts address and signature
    if (ctrl_wr_ev) begin
      nx.ctrl = ctrl_wr_val;
      if (!ctrl_wr_val[microport_pkg::CTRL_BOOT_BIT]) begin
        nx.fill_cnt = microport_pkg::FILL_RESET;
        nx.sig = microport_pkg::SIG_SEED;
      end
    end
  end

  // ==========================================================================
  // state register; reset gives the ready bootload state
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      // select synchroniser starts at the idle level: no false select edge
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.cs_s3 <= 1'b1;
      st.phase <= microport_pkg::ST_IDLE;
      st.ctrl <= microport_pkg::CTRL_RESET;
      st.sig <= microport_pkg::SIG_SEED;
      st.fill_cnt <= microport_pkg::FILL_RESET;
    end else begin
      st <= nx;
    end
  end

  // ==========================================================================
  // buffer between the fill logic and the program ram
  fill_fifo #(
    .WIDTH($bits(microport_pkg::fill_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fill_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_valid_i(st.push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(st.push_word),
    .out_valid_o(ram_valid_o),
    .out_ready_i(ram_ready_i),
    .out_data_o(ram_word_o)
  );

  // ==========================================================================
  // outputs straight from the state register
  assign serial_io_a_o = st.out_bit;
  assign serial_io_a_oe_o = st.oe;
  assign dev_addr_o = st.addr;
  assign dev_wdata_o = st.dev_wdata;
  assign dev_wr_o = st.dev_wr;
  assign boot_mode_o = st.ctrl[microport_pkg::CTRL_BOOT_BIT];
  assign exec_ram_o = st.ctrl[microport_pkg::CTRL_EXEC_BIT];

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // command byte finished, then one fetch cycle, then the data byte
  sequence seq_cmd_done;
    st.phase == microport_pkg::ST_CMD && sclk_rise && st.bit_cnt == microport_pkg::CMD_LAST_EDGE;
  endsequence
  sequence seq_fetch_data;
    st.phase == microport_pkg::ST_FETCH ##1 st.phase == microport_pkg::ST_DATA;
  endsequence

  // a bootload read: fetch picks signature or control, the next cycle drives it
  sequence seq_boot_fetch;
    st.phase == microport_pkg::ST_FETCH && st.rw && !st.cs_s2 &&
      st.ctrl[microport_pkg::CTRL_BOOT_BIT] && st.addr != microport_pkg::ADDR_CTRL;
  endsequence
  sequence seq_sig_fetch;
    seq_boot_fetch ##0 !st.addr[microport_pkg::ADDR_TOP_BIT];
  endsequence
  sequence seq_ctrl_fetch;
    seq_boot_fetch ##0 st.addr[microport_pkg::ADDR_TOP_BIT];
  endsequence

  chk_mode_lsb_pick: assert property (cs_fall && st.sclk_s2 |=> st.lsb_mode)
    else $error("lsb-first mode not chosen with clock high at select");
  chk_mode_msb_pick: assert property (cs_fall && !st.sclk_s2 |=>
    !st.lsb_mode && st.phase == microport_pkg::ST_CMD)
    else $error("msb-first mode not chosen with clock low at select");
  chk_drive_reads_only: assert property (st.oe |-> st.rw)
    else $error("shared line driven during a write");
  chk_cmd_byte_len: assert property (seq_cmd_done |=> seq_fetch_data)
    else $error("command byte not followed by fetch and data");
  chk_release_line: assert property (st.cs_s2 && $past(st.cs_s2) |-> !st.oe)
    else $error("shared line driven while select is high");
  chk_fill_cap: assert property (st.fill_cnt <= microport_pkg::FILL_LIMIT)
    else $error("fill count beyond program ram size");
  chk_sig_source: assert property ($changed(st.sig) |-> $past(fill_ev) || $past(ctrl_wr_ev))
    else $error("signature changed without a fill write");
  chk_read_keeps_fill: assert property (st.phase == microport_pkg::ST_DATA && st.rw |=>
    $stable(st.fill_cnt))
    else $error("read moved the fill address");
  chk_exit_boot_reset: assert property (ctrl_wr_ev &&
    !ctrl_wr_val[microport_pkg::CTRL_BOOT_BIT] |=>
    st.fill_cnt == microport_pkg::FILL_RESET && st.sig == microport_pkg::SIG_SEED)
    else $error("leaving bootload did not restart address and signature");
  chk_ctrl_no_fill: assert property (ctrl_wr_ev |=> !st.push_valid || $stable(st.push_word))
    else $error("control write queued a program ram byte");
  chk_boot_read_sig: assert property (seq_sig_fetch |=>
    st.oe && st.tx == $past(st.sig))
    else $error("bootload read of the signature returned something else");
  chk_boot_read_ctrl: assert property (seq_ctrl_fetch |=>
    st.oe && st.tx == {microport_pkg::CTRL_PAD, $past(st.ctrl)})
    else $error("bootload read of the control register returned something else");
  chk_fill_addr: assert property (fill_ev |=>
    st.push_valid && st.push_word.addr == $past(st.fill_cnt[11:0]))
    else $error("fill byte queued with an address other than the generated one");
  chk_dev_wr_normal: assert property (st.dev_wr |->
    !st.ctrl[microport_pkg::CTRL_BOOT_BIT] && st.addr != microport_pkg::ADDR_CTRL)
    else $error("device register written in bootload or at the control address");

endmodule : serial_microport_bootload

/* File: hw/microport_pkg.sv */
// constants, types and state layout shared by the serial microport design.
// assumes a single 100 MHz core clock; every pin arrives asynchronously.
package microport_pkg;

  // ==========================================================================
  // command/address decoding
  localparam logic [5:0] ADDR_CTRL = 6'h3F; // bootload control register
  localparam int MSB_RW_BIT = 7; // read flag position, msb-first mode
  localparam int LSB_RW_BIT = 0; // read flag position, lsb-first mode
  localparam int LSB_ADDR_POS = 2; // lowest address bit, lsb-first mode
  localparam int MSB_TOP_BIT = 7; // first data bit on the line, msb-first
  localparam int ADDR_TOP_BIT = 5; // address bit choosing ctrl or signature

  // ==========================================================================
  // serial framing counts
  localparam logic [4:0] CMD_LAST_EDGE = 5'h07; // eighth rising edge, 0 based
  localparam logic [4:0] DATA_FIRST_EDGE = 5'h08; // no shift before this
  localparam logic [4:0] DATA_LAST_EDGE = 5'h0F; // sixteenth rising edge

  // ==========================================================================
  // control register fields and reset values
  localparam int CTRL_BOOT_BIT = 2; // bootload enable
  localparam int CTRL_EXEC_BIT = 3; // execute from program ram
  localparam logic [3:0] CTRL_RESET = 4'h0; // rom execution, no bootload
  localparam logic [3:0] CTRL_PAD = 4'h0; // unused upper bits read as zero

  // ==========================================================================
  // fill address generator and signature
  localparam logic [12:0] FILL_LIMIT = 13'h1000; // bytes stored per bootload
  localparam logic [12:0] FILL_RESET = 13'h0000; // first program ram address
  localparam logic [7:0] SIG_SEED = 8'hFF; // signature start value
  localparam logic [7:0] SIG_POLY = 8'h1D; // x^8 + x^4 + x^3 + x^2 + 1

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE,  // chip select high
    ST_CMD,   // shifting the command/address byte
    ST_FETCH, // read value being selected
    ST_DATA,  // shifting the data byte
    ST_DONE   // waiting for chip select to rise
  } phase_e;

  // one program ram write as it travels through the buffer
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } fill_word_s;

  // complete state of the microport
  typedef struct packed {
    logic cs_s1, cs_s2, cs_s3; // chip select synchroniser plus history
    logic sclk_s1, sclk_s2, sclk_s3; // serial clock synchroniser plus history
    logic ioa_s1, ioa_s2; // bidirectional line input synchroniser
    logic rxb_s1, rxb_s2; // receive line synchroniser
    phase_e phase;
    logic lsb_mode; // lsb-first, single bidirectional line
    logic rw; // 1 = read
    logic [5:0] addr;
    logic [7:0] shreg; // receive shifter
    logic [4:0] bit_cnt; // rising edges seen in this session
    logic [7:0] tx; // transmit shifter
    logic oe; // drive serial_io_a
    logic out_bit;
    logic [3:0] ctrl;
    logic [7:0] sig;
    logic [12:0] fill_cnt;
    logic push_valid;
    fill_word_s push_word;
    logic dev_wr;
    logic [7:0] dev_wdata;
  } port_state_s;

endpackage : microport_pkg

/* File: hw/fill_fifo.sv */
// synchronous first-in first-out buffer with a registered read side.
// assumes both sides share the core clock; depth must be a power of two.
module fill_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  // ==========================================================================
  // elaboration checks
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fill_fifo depth must be a power of two of at least two");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("fill_fifo width must be positive");
  end

  // ==========================================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH]; // words not yet moved to the output
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count; // words held in mem
  logic full_reg; // registered so ready has no path from the drain side
  logic push;
  logic pop;
  logic [PW:0] count_next;

  // a word moves to the output register when it is empty or being taken
  assign push = in_valid_i && !full_reg;
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);
  assign in_ready_o = !full_reg;

  // count of stored words after this edge
  always_comb begin
    count_next = count;
    if (push && !pop) begin
      count_next = count + 1'b1;
    end else if (pop && !push) begin
      count_next = count - 1'b1;
    end
  end

  // memory array, no reset needed on the data
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers, flags and output register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full_reg <= 1'b0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      count <= count_next;
      full_reg <= (count_next == (PW + 1)'(DEPTH));
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data_o <= mem[rd_ptr];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end

endmodule : fill_fifo

/* File: verif/host_master.sv */
// host model: behavioural serial master running two-byte sessions on the pins.
// assumes clk_i is the 100 MHz core clock; one link half period is 8 of its cycles.
module host_master (
  // pacing clock
  input wire logic clk_i,
  // serial pins driven towards the device
  output logic cs_n_o,
  output logic sclk_o,
  output logic io_a_o,
  output logic io_a_en_o,
  output logic rx_b_o,
  // resolved shared line
  input wire logic io_a_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle pins at time zero
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_a_o = 1'b0;
    io_a_en_o = 1'b0;
    rx_b_o = 1'b0;
  end

  // ==========================================================
  // one session: command byte then data byte, nb rising edges in all
  task automatic xfer(input logic lsb, input logic rw, input logic [5:0] addr,
                      input logic [7:0] wd, input int nb, output logic [7:0] rd);
    logic [15:0] lv;
    logic [15:0] mv;
    logic bt;
    lv = {wd, addr, 1'b0, rw}; // lsb-first line order: flag, spare, a0..a5, d0..d7
    mv = {rw, 1'b0, addr, wd}; // msb-first line order: flag, spare, a5..a0, d7..d0
    rd = 8'h00;
    sclk_o = lsb; // clock level at select picks the framing
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b0; // one select spans both bytes
    repeat (8) @(negedge clk_i);
    for (int i = 0; i < nb; i++) begin
      sclk_o = 1'b0;
      bt = lsb ? lv[i] : mv[15-i];
      io_a_en_o = lsb && (i < 8 || !rw); // shared line only for host bits
      io_a_o = bt; // host bits change after the falling edge
      rx_b_o = (lsb || (rw && i > 7)) ? ~rx_b_o : bt; // noise where ignored
      repeat (8) @(negedge clk_i);
      if (i > 7) begin
        rd[lsb ? i - 8 : 15 - i] = io_a_i; // taken at the rising edge
      end
      sclk_o = 1'b1;
      // keep the last command bit steady past the synchroniser before letting go
      repeat (2) @(negedge clk_i);
      if (i == 7 && rw) begin
        io_a_en_o = 1'b0; // hand the shared line over for read data
      end
      repeat (6) @(negedge clk_i);
    end
    sclk_o = lsb;
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1; // end of session
    io_a_en_o = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask : xfer
endmodule : host_master

/* File: verif/serial_microport_bootload_tb_top.sv */
// testbench: register access, bootload fill, buffer stall and reset behaviour.
// assumes host_master drives the pins; device registers are a fixed pattern.
module serial_microport_bootload_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic ref_clk_i, reset_i, cs_n, sclk, io_host, io_host_en, rx_b, io_a_o, io_a_oe, ram_ready_i;
  logic io_a; // resolved shared line
  logic [5:0] dev_addr;
  logic [7:0] dev_wdata, rd, sig;
  logic dev_wr, ram_valid, boot_mode, exec_ram;
  microport_pkg::fill_word_s ram_word;
  microport_pkg::fill_word_s ram_q[$]; // words taken by the program ram
  logic [7:0] fill_d[16];
  int mismatches = 0, comparisons = 0, cycles = 0, wr_cnt = 0, n;

  // released line shows the inverse of the device bit, never a stale copy
  assign io_a = io_a_oe ? io_a_o : (io_host_en ? io_host : ~io_a_o);

  host_master u_host_master (.clk_i(ref_clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .io_a_o(io_host),
    .io_a_en_o(io_host_en), .rx_b_o(rx_b), .io_a_i(io_a));

  serial_microport_bootload #(.FIFO_DEPTH(16)) u_serial_microport_bootload (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .serial_io_a_i(io_a), .serial_io_a_o(io_a_o), .serial_io_a_oe_o(io_a_oe),
    .serial_rx_b_i(rx_b), .dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata), .dev_wr_o(dev_wr),
    .dev_rdata_i({dev_addr, 2'h3} ^ 8'h96), .ram_valid_o(ram_valid), .ram_word_o(ram_word),
    .ram_ready_i(ram_ready_i), .boot_mode_o(boot_mode), .exec_ram_o(exec_ram));

  // ==========================================================
  // clock and observers
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // count register write pulses and program ram handshakes; cut a hang short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (dev_wr === 1'b1) wr_cnt++;
    if (ram_valid === 1'b1 && ram_ready_i) ram_q.push_back(ram_word);
    if (cycles == 40000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic lsb, input logic [5:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    u_host_master.xfer(lsb, 1'b0, a, d, 16, dummy);
  endtask : wr

  task automatic rdc(input logic lsb, input logic [5:0] a, input logic [7:0] exp);
    u_host_master.xfer(lsb, 1'b1, a, 8'h00, 16, rd);
    chk("read data", rd, exp);
    chk("line released", io_a_oe, 1'b0);
  endtask : rdc

  // signature step kept here so the bench never borrows the design's arithmetic
  function automatic logic [7:0] sig_step(input logic [7:0] s, input logic [7:0] d);
    return ({s[6:0], 1'b0} ^ (s[7] ? microport_pkg::SIG_POLY : 8'h00)) ^ d;
  endfunction : sig_step

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // main sequence
  initial begin
    reset_i = 1'b1;
    ram_ready_i = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("idle line", io_a_oe, 1'b0);
    chk("ctrl reset", {boot_mode, exec_ram}, 2'h0);
    // ordinary access in both framings, plus an aborted session
    for (int m = 0; m < 2; m++) begin
      n = wr_cnt;
      wr(m[0], m ? 6'h2A : 6'h05, m ? 8'h3C : 8'hA5);
      chk("write pulse", wr_cnt - n, 1);
      chk("write addr", dev_addr, m ? 6'h2A : 6'h05);
      chk("write data", dev_wdata, m ? 8'h3C : 8'hA5);
      rdc(m[0], 6'h11, {6'h11, 2'h3} ^ 8'h96);
      u_host_master.xfer(m[0], 1'b0, 6'h07, 8'hFF, 10, rd);
      chk("abort no write", wr_cnt - n, 1);
    end
    // enter bootload and fill with the buffer stalled
    n = wr_cnt;
    wr(1'b1, microport_pkg::ADDR_CTRL, 8'h04);
    chk("boot on", {boot_mode, exec_ram}, 2'h2);
    sig = microport_pkg::SIG_SEED;
    for (int k = 0; k < 16; k++) begin
      fill_d[k] = 8'h10 + 8'(k * 37);
      wr(k[0], 6'h20 ^ 6'(k), fill_d[k]);
      sig = sig_step(sig, fill_d[k]);
      if (k == 7) begin
        rdc(1'b0, 6'h00, sig);
        rdc(1'b1, 6'h20, 8'h04);
      end
    end
    chk("no device writes", wr_cnt - n, 0);
    chk("stalled valid", ram_valid, 1'b1);
    wr(1'b0, microport_pkg::ADDR_CTRL, 8'h04);
    rdc(1'b1, 6'h01, sig);
    // drain with the ram side stalling every other cycle
    for (int k = 0; k < 64; k++) begin
      @(negedge ref_clk_i);
      ram_ready_i = k[0];
    end
    ram_ready_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk("fill count", ram_q.size(), 16);
    for (int k = 0; k < 16 && k < ram_q.size(); k++) begin
      chk("fill word", ram_q[k], {12'(k), fill_d[k]});
    end
    chk("drained", ram_valid, 1'b0);
    // leave bootload for ram execution, then start again from scratch
    wr(1'b1, microport_pkg::ADDR_CTRL, 8'h08);
    chk("exec ram", {boot_mode, exec_ram}, 2'h1);
    wr(1'b0, microport_pkg::ADDR_CTRL, 8'h04);
    rdc(1'b0, 6'h00, microport_pkg::SIG_SEED);
    wr(1'b0, 6'h09, 8'h77);
    chk("restart addr", ram_q[$], {12'h000, 8'h77});
    // hardware reset in the middle of a bootload
    reset_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("reset boot off", {boot_mode, exec_ram}, 2'h0);
    wr(1'b1, microport_pkg::ADDR_CTRL, 8'h04);
    rdc(1'b1, 6'h00, microport_pkg::SIG_SEED);
    wr(1'b1, 6'h00, 8'h5A);
    chk("reset fill addr", ram_q[$], {12'h000, 8'h5A});
    wr(1'b1, microport_pkg::ADDR_CTRL, 8'h00);
    chk("boot off", {boot_mode, exec_ram}, 2'h0);
    wrap_up();
  end
endmodule : serial_microport_bootload_tb_top
